// *** hw/boot_irq_pkg.sv ***
// Constants for the boot-mode latch and external request front end.
// Assumes a single 125 MHz core clock and a synchronous active-high reset.
package boot_irq_pkg;

   // ----------------------------------------
   // Widths and field positions
   // ----------------------------------------
   localparam int          NUM_REQ          = 4;
   localparam int          MODE_W           = 8;
   localparam int          BOOT_SEL_LSB     = 0;
   localparam int          STOP_DELAY_OFF_B = 6;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0]  MODE_RST         = 8'h00;
   localparam logic [3:0]  REQ_RST          = 4'h0;
   localparam logic [2:0]  SYNC_RST         = 3'h7;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_PERIOD_NS    = 8;
   localparam int          STOP_DELAY_NS    = 1000;
   localparam int          STOP_DELAY_CYC   = (STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  STOP_DELAY_LOAD  = 8'(STOP_DELAY_CYC);

   // ----------------------------------------
   // Core standby states
   // ----------------------------------------
   typedef enum logic [1:0] {RUN, WAIT_ST, STOP_ST} core_state_t;

endpackage

// *** hw/boot_irq_front.sv ***
// Boot-mode capture and external request front end on four shared pins.
// Assumes the pins arrive asynchronously and the core reports its standby state.
//
// How it works
// - On the cycle reset is released the four synchronised pins are stored as the boot mode.
// - After reset release the pins feed only the request logic, never the mode.
// - Each request has its own mask bit and its own level or falling-edge select.
// - Request 0 asserted ends both the stop and the wait state.
// - Requests 1 to 3 end only the wait state and never the stop state.
// - Reset sets rst_prev_q and clears all other state except the pin synchronisers and filtered pin levels, phase generator included.
// - Mode bit 6 low arms a stop-exit delay, high skips it.
`timescale 1ns/10ps
module boot_irq_front (
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_SRST,
   input  wire logic [3:0] I_PIN_N,
   input  wire logic [3:0] I_REQ_MASK,
   input  wire logic [3:0] I_EDGE_SEL,
   input  wire logic [3:0] I_REQ_ACK,
   input  wire logic       I_MODE_WR,
   input  wire logic [7:0] I_MODE_WDATA,
   input  wire logic       I_WAIT_ENTER,
   input  wire logic       I_STOP_ENTER,
   output logic      [7:0] O_MODE,
   output logic      [3:0] O_REQ,
   output logic            O_WAKE,
   output logic            O_IN_STANDBY,
   output logic            O_PHASE
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] s0_q [4];
   logic [2:0] s0_d [4];
   logic [3:0] act_q, act_d;
   logic [3:0] act_prev_q, act_prev_d;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         always_comb begin
            s0_d[g] = {s0_q[g][1:0], I_PIN_N[g]};
            act_d[g] = act_q[g];
            if (s0_q[g][1] == s0_q[g][2]) begin
               act_d[g] = ~s0_q[g][2];
            end
         end
         // The chain keeps sampling through reset so the boot levels are settled at release.
         always_ff @(posedge I_SYS_CLK) begin
            s0_q[g] <= s0_d[g];
         end
      end
   endgenerate

   // ----------------------------------------
   // Mode, requests, standby
   // ----------------------------------------
   logic        rst_prev_q, rst_prev_d;
   logic [7:0]  mode_q, mode_d;
   logic [3:0]  pend_q, pend_d;
   logic [3:0]  req_q, req_d;
   logic        wake_q, wake_d;
   logic [7:0]  dly_q, dly_d;
   logic        phase_q, phase_d;
   logic        stby_q, stby_d;
   boot_irq_pkg::core_state_t st_q, st_d;
   logic [3:0]  fall;
   logic [3:0]  live;

   always_comb begin
      rst_prev_d = 1'b0;
      act_prev_d = act_q;
      phase_d    = ~phase_q;
      mode_d     = mode_q;
      fall       = act_q & ~act_prev_q;
      pend_d     = pend_q;
      st_d       = st_q;
      dly_d      = dly_q;
      wake_d     = 1'b0;
      if (rst_prev_q) begin
         mode_d = {4'h0, act_d};
      end else if (I_MODE_WR) begin
         mode_d = I_MODE_WDATA;
      end
      for (int i = 0; i < 4; i++) begin
         if (I_REQ_ACK[i]) pend_d[i] = 1'b0;
         if (fall[i] && !rst_prev_q) pend_d[i] = 1'b1;
      end
      live  = I_EDGE_SEL & pend_q | ~I_EDGE_SEL & act_q;
      req_d = live & I_REQ_MASK;
      unique case (st_q)
         boot_irq_pkg::RUN: begin
            if (I_STOP_ENTER) st_d = boot_irq_pkg::STOP_ST;
            else if (I_WAIT_ENTER) st_d = boot_irq_pkg::WAIT_ST;
         end
         boot_irq_pkg::WAIT_ST: begin
            if (|act_q) begin
               st_d   = boot_irq_pkg::RUN;
               wake_d = 1'b1;
            end
         end
         boot_irq_pkg::STOP_ST: begin
            if (dly_q != 8'h00) begin
               dly_d = dly_q - 8'h01;
               if (dly_q == 8'h01) begin
                  st_d   = boot_irq_pkg::RUN;
                  wake_d = 1'b1;
               end
            end else if (act_q[0]) begin
               if (mode_q[boot_irq_pkg::STOP_DELAY_OFF_B]) begin
                  st_d   = boot_irq_pkg::RUN;
                  wake_d = 1'b1;
               end else begin
                  dly_d = boot_irq_pkg::STOP_DELAY_LOAD;
               end
            end
         end
      endcase
      stby_d = (st_d != boot_irq_pkg::RUN);
   end

   // The filtered pin levels follow the pins through reset, so the boot mode can be
   // captured at release and no false edge is seen then.
   always_ff @(posedge I_SYS_CLK) begin
      act_q      <= act_d;
      act_prev_q <= act_prev_d;
      if (I_SRST) begin
         rst_prev_q <= 1'b1;
         mode_q     <= boot_irq_pkg::MODE_RST;
         pend_q     <= boot_irq_pkg::REQ_RST;
         req_q      <= boot_irq_pkg::REQ_RST;
         wake_q     <= 1'b0;
         dly_q      <= 8'h00;
         phase_q    <= 1'b0;
         st_q       <= boot_irq_pkg::RUN;
         stby_q     <= 1'b0;
      end else begin
         rst_prev_q <= rst_prev_d;
         mode_q     <= mode_d;
         pend_q     <= pend_d;
         req_q      <= req_d;
         wake_q     <= wake_d;
         dly_q      <= dly_d;
         phase_q    <= phase_d;
         st_q       <= st_d;
         stby_q     <= stby_d;
      end
   end

   assign O_MODE       = mode_q;
   assign O_REQ        = req_q;
   assign O_WAKE       = wake_q;
   assign O_IN_STANDBY = stby_q;
   assign O_PHASE      = phase_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_mode_latch: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      rst_prev_q |=> mode_q[3:0] == $past(act_d))
      else $error("boot mode not latched at reset release");
   chk_mask_gates: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      ##1 (O_REQ & ~$past(I_REQ_MASK)) == 4'h0)
      else $error("masked request reached output");
   chk_stop_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (st_q == boot_irq_pkg::STOP_ST && dly_q == 8'h00 && !act_q[0])
      |=> st_q == boot_irq_pkg::STOP_ST)
      else $error("stop left without request 0");
   chk_wait_exit: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (st_q == boot_irq_pkg::WAIT_ST && |act_q) |=> O_WAKE && st_q == boot_irq_pkg::RUN)
      else $error("wait not left on request");
   chk_stop_fast: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (st_q == boot_irq_pkg::STOP_ST && dly_q == 8'h00 && act_q[0] && mode_q[6]) |=> O_WAKE)
      else $error("stop exit delayed while disabled");
   chk_stop_delay: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (st_q == boot_irq_pkg::STOP_ST && dly_q == 8'h00 && act_q[0] && !mode_q[6])
      |=> !O_WAKE ##1 !O_WAKE)
      else $error("stop exit too early");
   chk_edge_pend: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (fall[0] && !rst_prev_q && !I_REQ_ACK[0]) |=> pend_q[0])
      else $error("falling edge not held pending");
   chk_reset_state: assert property (@(posedge I_SYS_CLK)
      I_SRST |=> O_REQ == 4'h0 && !O_WAKE && !O_PHASE)
      else $error("reset did not clear state");

endmodule

// *** testbench/board_model.sv ***
// Board logic that drives the four shared pins.
// Assumes the bench reports when it holds the chip in reset.
`timescale 1ns/10ps
module board_model (
   input  wire logic       i_rst,
   input  wire logic [3:0] i_boot,
   input  wire logic [3:0] i_req,
   output logic      [3:0] o_pin_n
);
   // ------------------------------
   // Pin levels
   // ------------------------------
   // Boot levels stand through reset, requests follow it; both active low.
   assign o_pin_n = i_rst ? ~i_boot : ~i_req;
endmodule

// *** testbench/boot_irq_front_tb_top.sv ***
// Self-checking bench for the boot-mode and request front end.
// Assumes the board model drives the pins and the bench plays the core.
`timescale 1ns/10ps
module boot_irq_front_tb_top;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic [3:0] boot, req, mask, esel, ack, pin_n, oreq;
   logic [7:0] mode, mwd;
   logic       mwr, wen, sen, wake, stby, phase;
   int         miscompares = 0;
   int         checked = 0;
   int         cyc = 0;
   int         n;
   // ------------------------------
   // Clock, timeout and helpers
   // ------------------------------
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         results();
      end
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wake_in(input int lim, output int w);
      w = 0;
      do begin
         @(negedge clk);
         w++;
      end while (wake !== 1'b1 && w < lim);
   endtask
   task automatic pulse_core(input logic [7:0] wd, input logic w, input logic s);
      @(posedge clk);
      mwr <= (wd != 8'hff);
      mwd <= wd;
      wen <= w;
      sen <= s;
      @(posedge clk);
      {mwr, wen, sen} <= 3'h0;
      tick(3);
   endtask
   task automatic results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------
   // Instances
   // ------------------------------
   board_model board_model_i (.i_rst(srst), .i_boot(boot), .i_req(req), .o_pin_n(pin_n));
   boot_irq_front boot_irq_front_i (
      .I_SYS_CLK(clk), .I_SRST(srst), .I_PIN_N(pin_n), .I_REQ_MASK(mask),
      .I_EDGE_SEL(esel), .I_REQ_ACK(ack), .I_MODE_WR(mwr), .I_MODE_WDATA(mwd),
      .I_WAIT_ENTER(wen), .I_STOP_ENTER(sen), .O_MODE(mode), .O_REQ(oreq),
      .O_WAKE(wake), .O_IN_STANDBY(stby), .O_PHASE(phase));
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      n = $urandom(24);
      boot = 4'($urandom);
      {req, mask, esel, ack, mwr, wen, sen, mwd} = 27'h0;
      tick(15);
      @(negedge clk);
      cmp({oreq, wake, stby, phase, 1'b0}, 8'h00);
      @(posedge clk);
      srst <= 1'b0;
      tick(3);
      @(negedge clk);
      cmp(mode, {4'h0, boot});
      cmp({7'h0, phase}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         req <= 4'($urandom);
         mask <= (i == 0) ? 4'h0 : 4'($urandom);
         tick(10);
         @(negedge clk);
         cmp({4'h0, oreq}, {4'h0, req & mask});
      end
      cmp(mode, {4'h0, boot});
      @(posedge clk);
      {req, mask} <= 8'h0f;
      tick(10);
      esel <= 4'hf;
      tick(2);
      req <= 4'hf;
      tick(4);
      req <= 4'h0;
      tick(10);
      @(negedge clk);
      cmp({4'h0, oreq}, 8'h0f);
      @(posedge clk);
      ack <= 4'h5;
      @(posedge clk);
      ack <= 4'h0;
      tick(3);
      @(negedge clk);
      cmp({4'h0, oreq}, 8'h0a);
      pulse_core({4'h4, boot}, 1'b0, 1'b1);
      req <= 4'h2;
      tick(12);
      @(negedge clk);
      cmp({7'h0, stby}, 8'h01);
      @(posedge clk);
      req <= 4'h1;
      wake_in(20, n);
      cmp({7'h0, wake}, 8'h01);
      @(posedge clk);
      req <= 4'h0;
      tick(8);
      pulse_core(8'hff, 1'b1, 1'b0);
      req <= 4'h8;
      wake_in(20, n);
      cmp({7'h0, wake}, 8'h01);
      pulse_core({4'h0, boot}, 1'b0, 1'b1);
      req <= 4'h1;
      wake_in(300, n);
      cmp({7'h0, n > boot_irq_pkg::STOP_DELAY_CYC && n < boot_irq_pkg::STOP_DELAY_CYC + 20}, 8'h01);
      results();
   end
endmodule
